// ### verilog/adma_pkg.sv
// Notes on behaviour
// - count-register snoop loads DMA count in the data phase
// - direction bit loaded from address bit 2 on snoop, from data bit 24 on pass-thru
// - snoop slave: data phase, recovery, idle
// - read enable needs read direction, nonzero count
// - write enable also held while FIFO holds data
// - enables only after address and count written
// - flush receive FIFO in recovery at zero count
// - never push FIFO without valid data
// - processor-less: always bus master, outputs driven
// - master leaves idle on request, count not done
// - no DMA start during pass-thru register access
// - attention means read pass-thru data register
// - pass-thru slave starts only with master idle
// - address state strobes, decodes region and bit 2
// - write states strobe read/done, back to idle
// - address snoop keeps lower 22 bits
// - address registers at offsets 30h and 24h
// - count registers at offsets 5Ch and 58h
// - reset clears count, direction, both machines
`default_nettype none
package adma_pkg;
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          DMA_ADDR_W    = 22;
   localparam int          DMA_CNT_W     = 18;
   localparam int          WORD_BYTES    = 4;
   localparam int          WORD_LSB      = 2;
   localparam int          DIR_DATA_BIT  = 24;
   localparam int          A2_BIT        = 2;
   // chip operation registers seen on the add-on bus
   localparam logic [7:0]  OFF_RD_ADDR   = 8'h30;
   localparam logic [7:0]  OFF_WR_ADDR   = 8'h24;
   localparam logic [7:0]  OFF_RD_CNT    = 8'h5C;
   localparam logic [7:0]  OFF_WR_CNT    = 8'h58;
   localparam logic [1:0]  PT_REGION_HIT = 2'h3;
   // local register map
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_STATUS    = 8'h04;
   localparam logic [7:0]  REG_COUNT     = 8'h08;
   localparam logic [7:0]  REG_ADDR      = 8'h0C;
   localparam int          CTRL_PT_BIT   = 0;
   localparam logic [31:0] RDATA_NONE    = 32'h0000_0000;

   typedef enum logic [1:0] {
      M_IDLE  = 2'h0,
      M_ADDR  = 2'h1,
      M_DATA  = 2'h3,
      M_RECOV = 2'h2
   } adma_mst_t;

   typedef enum logic [2:0] {
      S_IDLE    = 3'h0,
      S_SNP_ADR = 3'h1,
      S_SNP_CNT = 3'h3,
      S_SNP_REC = 3'h2,
      S_PT_DEC  = 3'h6,
      S_PT_ADR  = 3'h7,
      S_PT_CNT  = 3'h5
   } adma_slv_t;
endpackage : adma_pkg
`default_nettype wire

// ### verilog/adma_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
// handshake between the master side and the register-load slave
interface adma_ctl_if;
   logic pt_mode;
   logic master_idle;
   logic slave_idle;
   logic load_addr;
   logic load_count;
   logic dir_val;
   logic pt_adr_n;
   logic pt_rd_n;
   modport dma (output pt_mode, output master_idle, input slave_idle,
                input load_addr, input load_count, input dir_val,
                input pt_adr_n, input pt_rd_n);
   modport slv (input pt_mode, input master_idle, output slave_idle,
                output load_addr, output load_count, output dir_val,
                output pt_adr_n, output pt_rd_n);
endinterface : adma_ctl_if
`default_nettype wire

// ### verilog/adma_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; a change counts once stages 2 and 3 agree
module adma_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] stable_o
);
   logic [W-1:0] s1, s2, s3;
   logic [W-1:0] next_stable;

   // per-bit filter; s1 feeds only s2
   always_comb begin
      for (int i = 0; i < W; i++) begin
         next_stable[i] = (s2[i] == s3[i]) ? s3[i] : stable_o[i];
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1       <= '0;
         s2       <= '0;
         s3       <= '0;
         stable_o <= '0;
      end else begin
         s1       <= pin_i;
         s2       <= s1;
         s3       <= s2;
         stable_o <= next_stable;
      end
   end
endmodule : adma_sync
`default_nettype wire

// ### verilog/adma_slave.sv
`timescale 1ns/1ps
`default_nettype none
// snoop of chip register writes and pass-thru programming sequencer
module adma_slave (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   adma_ctl_if.slv          ctl,
   input  wire logic        addr_strobe_n_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        hold_ack_i,
   input  wire logic [31:0] ad_i,
   input  wire logic        passthru_attn_n_i,
   input  wire logic [1:0]  passthru_region_i
);
   adma_pkg::adma_slv_t state, next_state;
   logic                dir_hold, next_dir_hold;
   logic                attn_wait, next_attn_wait;
   logic                snoop_go, addr_hit, cnt_hit;

   // chip register decode on address lines 6:2
   always_comb begin
      snoop_go = !addr_strobe_n_i && !chip_select_n_i && !hold_ack_i
                 && !ctl.pt_mode;
      addr_hit = (ad_i[6:2] == adma_pkg::OFF_RD_ADDR[6:2])
              || (ad_i[6:2] == adma_pkg::OFF_WR_ADDR[6:2]);
      cnt_hit  = (ad_i[6:2] == adma_pkg::OFF_RD_CNT[6:2])
              || (ad_i[6:2] == adma_pkg::OFF_WR_CNT[6:2]);
   end

   // next state; snoop and pass-thru never run together
   always_comb begin
      next_state     = state;
      next_dir_hold  = dir_hold;
      // filtered attention lags the answer; serve one request only once
      next_attn_wait = attn_wait && !passthru_attn_n_i;
      case (state)
         adma_pkg::S_IDLE: begin
            if (ctl.pt_mode) begin
               if (!passthru_attn_n_i && ctl.master_idle && !attn_wait) begin
                  next_state     = adma_pkg::S_PT_DEC;
                  next_attn_wait = 1'b1;
               end
            end else if (snoop_go && addr_hit) begin
               next_state = adma_pkg::S_SNP_ADR;
            end else if (snoop_go && cnt_hit) begin
               next_state    = adma_pkg::S_SNP_CNT;
               next_dir_hold = ad_i[adma_pkg::A2_BIT];
            end
         end
         // address stands two filtered cycles; data follows the strobe
         adma_pkg::S_SNP_ADR, adma_pkg::S_SNP_CNT: begin
            if (addr_strobe_n_i) begin
               next_state = adma_pkg::S_SNP_REC;
            end
         end
         adma_pkg::S_SNP_REC: next_state = adma_pkg::S_IDLE;
         adma_pkg::S_PT_DEC: begin
            // region hit plus bit 2 picks the register
            if (passthru_region_i == adma_pkg::PT_REGION_HIT) begin
               next_state = ad_i[adma_pkg::A2_BIT] ? adma_pkg::S_PT_ADR
                                                   : adma_pkg::S_PT_CNT;
            end else begin
               next_state = adma_pkg::S_IDLE;
            end
         end
         adma_pkg::S_PT_ADR: next_state = adma_pkg::S_IDLE;
         adma_pkg::S_PT_CNT: next_state = adma_pkg::S_IDLE;
         default:            next_state = adma_pkg::S_IDLE;
      endcase
   end

   // strobes registered from the next state so they match the state
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state        <= adma_pkg::S_IDLE;
         dir_hold     <= 1'b0;
         attn_wait    <= 1'b0;
         ctl.pt_adr_n <= 1'b1;
         ctl.pt_rd_n  <= 1'b1;
      end else begin
         state        <= next_state;
         dir_hold     <= next_dir_hold;
         attn_wait    <= next_attn_wait;
         ctl.pt_adr_n <= !(next_state == adma_pkg::S_PT_DEC);
         ctl.pt_rd_n  <= !((next_state == adma_pkg::S_PT_ADR)
                        || (next_state == adma_pkg::S_PT_CNT));
      end
   end

   // loads happen in the data phase, when the value is on the bus
   always_comb begin
      ctl.slave_idle = (state == adma_pkg::S_IDLE);
      ctl.load_addr  = (state == adma_pkg::S_SNP_ADR && addr_strobe_n_i)
                    || (state == adma_pkg::S_PT_ADR);
      ctl.load_count = (state == adma_pkg::S_SNP_CNT && addr_strobe_n_i)
                    || (state == adma_pkg::S_PT_CNT);
      // pass-thru has no bit 2 hint, so the written word carries it
      ctl.dir_val    = (state == adma_pkg::S_PT_CNT)
                     ? ad_i[adma_pkg::DIR_DATA_BIT] : dir_hold;
   end

   sequence s_snoop_tail;
      state == adma_pkg::S_SNP_REC ##1 state == adma_pkg::S_IDLE;
   endsequence

   chk_snoop_recovery: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      (state == adma_pkg::S_SNP_ADR || state == adma_pkg::S_SNP_CNT)
      && addr_strobe_n_i |=> s_snoop_tail)
      else $error("snoop data phase not followed by recovery then idle");

   chk_pt_start_gate: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      (state == adma_pkg::S_IDLE && !ctl.master_idle)
      |=> state != adma_pkg::S_PT_DEC)
      else $error("pass-thru started while master busy");

   chk_pt_single_run: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      (state == adma_pkg::S_IDLE && attn_wait)
      |=> state != adma_pkg::S_PT_DEC)
      else $error("pass-thru request served twice");

   chk_pt_write_done: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      (state == adma_pkg::S_PT_ADR || state == adma_pkg::S_PT_CNT)
      |-> !ctl.pt_rd_n ##1 (state == adma_pkg::S_IDLE && ctl.pt_rd_n))
      else $error("pass-thru write state strobe or exit wrong");

   chk_pt_addr_strobe: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      (state == adma_pkg::S_PT_DEC) == !ctl.pt_adr_n)
      else $error("pass-thru address strobe out of its state");
endmodule : adma_slave
`default_nettype wire

// ### verilog/adma_top.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// add-on DMA setup snoop, master enables and pass-thru programming
module adma_top #(
   parameter int ADDR_W = adma_pkg::DMA_ADDR_W,
   parameter int CNT_W  = adma_pkg::DMA_CNT_W
) (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   // local register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // add-on bus, from the pins
   input  wire logic        addr_strobe_n_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        hold_ack_i,
   input  wire logic [31:0] ad_i,
   input  wire logic        rx_fifo_empty_i,
   input  wire logic        tx_fifo_full_i,
   input  wire logic        tx_fifo_empty_i,
   input  wire logic        passthru_attn_n_i,
   input  wire logic [1:0]  passthru_region_i,
   // add-on bus master side
   output logic [31:0]      ad_o,
   output logic             ad_oe_o,
   output logic             addr_strobe_n_o,
   output logic [3:0]       byte_en_n_o,
   output logic             w_nr_o,
   output logic             bus_oe_o,
   output logic             hold_req_o,
   output logic             fifo_pop_n_o,
   output logic             fifo_push_n_o,
   // chip control
   output logic             pci_master_rd_enable_o,
   output logic             pci_master_wr_enable_o,
   output logic             rx_fifo_flush_n_o,
   output logic             tx_fifo_flush_n_o,
   output logic             passthru_addr_strobe_n_o,
   output logic             chip_rd_n_o,
   output logic             passthru_done_n_o
);
   localparam int SYNC_W = 41;

   adma_ctl_if ctl ();

   logic [SYNC_W-1:0] pins_s;
   logic              as_n_s, cs_n_s, hold_ack_s, rx_empty_s, tx_full_s;
   logic              tx_empty_s, attn_n_s;
   logic [1:0]        region_s;
   logic [31:0]       ad_s;

   // every pin goes through the same three-stage filter
   adma_sync #(.W(SYNC_W)) u_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     ({addr_strobe_n_i, chip_select_n_i, hold_ack_i, ad_i,
                   rx_fifo_empty_i, tx_fifo_full_i, tx_fifo_empty_i,
                   passthru_attn_n_i, passthru_region_i}),
      .stable_o  (pins_s)
   );

   assign {as_n_s, cs_n_s, hold_ack_s, ad_s, rx_empty_s, tx_full_s,
           tx_empty_s, attn_n_s, region_s} = pins_s;

   adma_slave u_slave (
      .ref_clk_i         (ref_clk_i),
      .sys_rst_i         (sys_rst_i),
      .ctl               (ctl.slv),
      .addr_strobe_n_i   (as_n_s),
      .chip_select_n_i   (cs_n_s),
      .hold_ack_i        (hold_ack_s),
      .ad_i              (ad_s),
      .passthru_attn_n_i (attn_n_s),
      .passthru_region_i (region_s)
   );

   // dma state
   adma_pkg::adma_mst_t m_state, next_m_state;
   logic [ADDR_W-1:0]   dma_addr, next_dma_addr;
   logic [CNT_W-1:0]    dma_count, next_dma_count;
   logic                dir_bit, next_dir_bit;
   logic                addr_set, next_addr_set;
   logic                count_set, next_count_set;
   logic                pt_mode, next_pt_mode;
   logic                done, armed, req_ok, stop, granted, xfer;
   logic                finish;

   // count kept in bytes; only whole words are moved
   always_comb begin
      done    = (dma_count[CNT_W-1:adma_pkg::WORD_LSB] == '0);
      armed   = addr_set && count_set;
      stop    = (dir_bit && rx_empty_s) || (!dir_bit && tx_full_s);
      req_ok  = !done && !stop;
      granted = pt_mode || hold_ack_s;
      xfer    = (m_state == adma_pkg::M_DATA) && !stop;
      finish  = (m_state == adma_pkg::M_RECOV) && done
                && (dir_bit || tx_empty_s);
   end

   // master sequencer, reduced to one data phase per pass
   always_comb begin
      next_m_state = m_state;
      case (m_state)
         adma_pkg::M_IDLE: begin
            if (req_ok && armed) begin
               next_m_state = adma_pkg::M_ADDR;
            end
         end
         adma_pkg::M_ADDR: begin
            // waits here while a pass-thru load is running
            if (ctl.slave_idle && granted) begin
               next_m_state = adma_pkg::M_DATA;
            end
         end
         adma_pkg::M_DATA: next_m_state = adma_pkg::M_RECOV;
         adma_pkg::M_RECOV: begin
            next_m_state = (req_ok && armed) ? adma_pkg::M_ADDR
                                             : adma_pkg::M_IDLE;
         end
         default: next_m_state = adma_pkg::M_IDLE;
      endcase
   end

   // address, count and direction; a load beats a data-phase update
   always_comb begin
      next_dma_addr  = dma_addr;
      next_dma_count = dma_count;
      next_dir_bit   = dir_bit;
      next_addr_set  = addr_set;
      next_count_set = count_set;
      if (xfer) begin
         next_dma_addr  = dma_addr + ADDR_W'(adma_pkg::WORD_BYTES);
         next_dma_count = dma_count - CNT_W'(adma_pkg::WORD_BYTES);
      end
      if (finish) begin
         next_addr_set  = 1'b0;
         next_count_set = 1'b0;
      end
      if (ctl.load_addr) begin
         next_dma_addr = ad_s[ADDR_W-1:0];
         next_addr_set = 1'b1;
      end
      if (ctl.load_count) begin
         next_dma_count = ad_s[CNT_W-1:0];
         next_dir_bit   = ctl.dir_val;
         next_count_set = 1'b1;
      end
   end

   // register port writes
   always_comb begin
      next_pt_mode = pt_mode;
      if (reg_wr_i && reg_addr_i == adma_pkg::REG_CTRL) begin
         next_pt_mode = reg_wdata_i[adma_pkg::CTRL_PT_BIT];
      end
   end

   always_comb begin
      ctl.pt_mode     = pt_mode;
      ctl.master_idle = (m_state == adma_pkg::M_IDLE);
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         m_state   <= adma_pkg::M_IDLE;
         dma_addr  <= '0;
         dma_count <= '0;
         dir_bit   <= 1'b0;
         addr_set  <= 1'b0;
         count_set <= 1'b0;
         pt_mode   <= 1'b0;
      end else begin
         m_state   <= next_m_state;
         dma_addr  <= next_dma_addr;
         dma_count <= next_dma_count;
         dir_bit   <= next_dir_bit;
         addr_set  <= next_addr_set;
         count_set <= next_count_set;
         pt_mode   <= next_pt_mode;
      end
   end

   // registered pin outputs
   logic        next_rd_en, next_wr_en, next_rx_flush_n;
   logic        next_pop_n, next_push_n;
   logic [31:0] next_rdata;

   always_comb begin
      next_rd_en      = armed && dir_bit && !done;
      // stays on after zero count until the chip drains its FIFO
      next_wr_en      = armed && !dir_bit
                        && (!done || !tx_empty_s);
      next_rx_flush_n = !(done && dir_bit
                        && m_state == adma_pkg::M_RECOV);
      next_pop_n      = !(xfer && dir_bit);
      next_push_n     = !(xfer && !dir_bit);
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_comb begin
      next_rdata = adma_pkg::RDATA_NONE;
      if (reg_rd_i) begin
         case (reg_addr_i)
            adma_pkg::REG_CTRL:   next_rdata = {31'h0000_0000, pt_mode};
            adma_pkg::REG_STATUS: next_rdata = {24'h00_0000, m_state,
                                   pci_master_rd_enable_o,
                                   pci_master_wr_enable_o, dir_bit,
                                   done, addr_set, count_set};
            adma_pkg::REG_COUNT:  next_rdata = 32'(dma_count);
            adma_pkg::REG_ADDR:   next_rdata = 32'(dma_addr);
            default:              next_rdata = adma_pkg::RDATA_NONE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o            <= '0;
         pci_master_rd_enable_o <= 1'b0;
         pci_master_wr_enable_o <= 1'b0;
         rx_fifo_flush_n_o      <= 1'b1;
         tx_fifo_flush_n_o      <= 1'b1;
         fifo_pop_n_o           <= 1'b1;
         fifo_push_n_o          <= 1'b1;
         ad_o                   <= '0;
         ad_oe_o                <= 1'b0;
         addr_strobe_n_o        <= 1'b1;
         byte_en_n_o            <= 4'hF;
         w_nr_o                 <= 1'b0;
         bus_oe_o               <= 1'b0;
         hold_req_o             <= 1'b0;
      end else begin
         reg_rdata_o            <= next_rdata;
         pci_master_rd_enable_o <= next_rd_en;
         pci_master_wr_enable_o <= next_wr_en;
         rx_fifo_flush_n_o      <= next_rx_flush_n;
         // no stray pushes, so the transmit FIFO never needs a flush
         tx_fifo_flush_n_o      <= 1'b1;
         fifo_pop_n_o           <= next_pop_n;
         fifo_push_n_o          <= next_push_n;
         ad_o                   <= 32'(dma_addr);
         ad_oe_o                <= (next_m_state == adma_pkg::M_ADDR);
         addr_strobe_n_o        <= !(next_m_state == adma_pkg::M_ADDR);
         byte_en_n_o            <= 4'h0;
         w_nr_o                 <= next_dir_bit;
         bus_oe_o               <= next_pt_mode || hold_ack_s;
         hold_req_o             <= !next_pt_mode
                                   && next_m_state != adma_pkg::M_IDLE;
      end
   end

   // pass-thru strobes are already flops in the slave
   assign passthru_addr_strobe_n_o = ctl.pt_adr_n;
   assign chip_rd_n_o              = ctl.pt_rd_n;
   assign passthru_done_n_o        = ctl.pt_rd_n;

   sequence s_leave_idle;
      m_state == adma_pkg::M_IDLE ##1 m_state == adma_pkg::M_ADDR;
   endsequence

   chk_master_start: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      s_leave_idle |-> $past(req_ok && armed))
      else $error("master left idle without a request");

   chk_pt_blocks_dma: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      (m_state == adma_pkg::M_ADDR && !ctl.slave_idle)
      |=> m_state == adma_pkg::M_ADDR)
      else $error("dma began during a pass-thru access");

   chk_count_snoop: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      ctl.load_count |=> dma_count == $past(ad_s[CNT_W-1:0]))
      else $error("count not loaded from bus");

   chk_dir_load: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      ctl.load_count |=> dir_bit == $past(ctl.dir_val))
      else $error("direction not loaded with count");

   chk_addr_snoop: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      ctl.load_addr |=> dma_addr == $past(ad_s[ADDR_W-1:0]))
      else $error("address not loaded from bus");

   chk_rd_enable: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      ##1 pci_master_rd_enable_o == $past(armed && dir_bit && !done))
      else $error("read enable does not follow direction and count");

   chk_wr_enable: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      ##1 pci_master_wr_enable_o
          == $past(armed && !dir_bit && (!done || !tx_empty_s)))
      else $error("write enable does not follow count and fifo");

   chk_rx_flush: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      (m_state == adma_pkg::M_RECOV && done && dir_bit)
      |=> !rx_fifo_flush_n_o)
      else $error("receive fifo not flushed at end of read");

   chk_push_valid: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      !fifo_push_n_o |-> $past(m_state == adma_pkg::M_DATA
                               && !dir_bit && !tx_full_s))
      else $error("fifo push without valid data");
endmodule : adma_top
`default_nettype wire

// ### sim/adma_chip_model.sv
`timescale 1ns/1ps
`default_nettype none
// chip add-on side: snooped register writes and pass-thru requests
module adma_chip_model (
   input  wire logic   clk_i,
   input  wire logic   done_n_i,
   input  wire logic   hold_req_i,
   output logic        strb_n_o,
   output logic        sel_n_o,
   output logic [31:0] ad_o,
   output logic        attn_n_o,
   output logic        hold_ack_o
);
   // local processor grants the add-on bus one cycle after the request
   always @(posedge clk_i) hold_ack_o <= hold_req_i;
   initial {strb_n_o, sel_n_o, attn_n_o, ad_o} = {3'h7, 32'h0000_0000};
   // two address cycles so the pin filter sees them; released bus inverts
   task automatic wr(input logic [7:0] off, input logic [31:0] v);
      @(posedge clk_i) {strb_n_o, sel_n_o, ad_o} <= {26'h000_0000, off};
      repeat (2) @(posedge clk_i);
      {strb_n_o, ad_o} <= {1'b1, v};
      repeat (4) @(posedge clk_i);
      {sel_n_o, ad_o} <= {1'b1, ~v};
      repeat (6) @(posedge clk_i);
   endtask : wr
   // attention held until the design answers or 40 cycles pass; region is driven by the testbench, 3 then 1
   task automatic pt(input logic [31:0] v);
      @(posedge clk_i) {attn_n_o, ad_o} <= {1'b0, v};
      for (int i = 0; i < 40 && done_n_i !== 1'b0; i++) @(negedge clk_i);
      @(posedge clk_i) {attn_n_o, ad_o} <= {1'b1, ~v};
      repeat (10) @(posedge clk_i);
   endtask : pt
endmodule : adma_chip_model
`default_nettype wire

// ### sim/adma_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adma_top_tb;
   logic        ref_clk_i, sys_rst_i, reg_wr_i, reg_rd_i;
   logic [7:0]  reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, ad, ad_out, last_ad;
   logic        rx_e, tx_f, tx_e, strb_n, sel_n, attn_n, pop_n, push_n;
   logic        rd_en, wr_en, flush_n, done_n, hold_req, bus_oe, hold_ack;
   logic        ad_oe, ads_n, w_nr, tx_flush_n, adr_n, rd_n;
   logic [1:0]  region;
   logic [3:0]  be_n;
   int          err_total, checks, pops, pushes, flushes, dones, adrs, rds;
   adma_top i_adma_top (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .addr_strobe_n_i(strb_n), .chip_select_n_i(sel_n), .hold_ack_i(hold_ack),
      .ad_i(ad), .rx_fifo_empty_i(rx_e), .tx_fifo_full_i(tx_f),
      .tx_fifo_empty_i(tx_e), .passthru_attn_n_i(attn_n),
      .passthru_region_i(region), .ad_o(ad_out), .ad_oe_o(ad_oe),
      .addr_strobe_n_o(ads_n), .byte_en_n_o(be_n), .w_nr_o(w_nr),
      .bus_oe_o(bus_oe), .hold_req_o(hold_req),
      .fifo_pop_n_o(pop_n), .fifo_push_n_o(push_n),
      .pci_master_rd_enable_o(rd_en), .pci_master_wr_enable_o(wr_en),
      .rx_fifo_flush_n_o(flush_n), .tx_fifo_flush_n_o(tx_flush_n),
      .passthru_addr_strobe_n_o(adr_n), .chip_rd_n_o(rd_n),
      .passthru_done_n_o(done_n));
   adma_chip_model i_adma_chip_model (.clk_i(ref_clk_i), .done_n_i(done_n),
      .hold_req_i(hold_req), .strb_n_o(strb_n), .sel_n_o(sel_n), .ad_o(ad),
      .attn_n_o(attn_n), .hold_ack_o(hold_ack));
   // tallies of the one-cycle active-low pulses
   always @(negedge pop_n) pops++;
   always @(negedge push_n) pushes++;
   always @(negedge flush_n) flushes++;
   always @(negedge done_n) dones++;
   always @(negedge adr_n) adrs++;
   always @(negedge rd_n) rds++;
   // address driven with its strobe in each master address phase
   always @(negedge ref_clk_i) begin
      if (ad_oe === 1'b1 && ads_n === 1'b0) last_ad = ad_out;
   end
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic cmpb(input logic g, input logic e);
      cmp({31'h0000_0000, g}, {31'h0000_0000, e});
   endtask : cmpb
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge ref_clk_i) reg_rd_i <= 1'b0;
      @(negedge ref_clk_i) cmp(reg_rdata_o, e);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
      @(posedge ref_clk_i) reg_wr_i <= 1'b0;
   endtask : wr
   task automatic summarize();
      $display("errors %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   // watchdog well past the expected run length
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      err_total++;
      summarize();
   end
   initial begin
      {sys_rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 43'h400_0000_0000;
      {rx_e, tx_f, tx_e, region} = 5'h1B;
      repeat (10) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rd(adma_pkg::REG_COUNT, 32'h0000_0000);
      rd(adma_pkg::REG_STATUS, 32'h0000_0004);
      i_adma_chip_model.wr(8'h40, 32'h0000_0005);
      rd(adma_pkg::REG_COUNT, 32'h0000_0000);
      i_adma_chip_model.wr(adma_pkg::OFF_RD_ADDR, 32'hFFC0_0100);
      i_adma_chip_model.wr(adma_pkg::OFF_RD_CNT, 32'h0000_0008);
      rd(adma_pkg::REG_ADDR, 32'h0000_0100);
      rd(adma_pkg::REG_COUNT, 32'h0000_0008);
      cmpb(rd_en, 1'b1);
      cmpb(wr_en, 1'b0);
      cmpb(w_nr, 1'b1);
      cmp({28'h000_0000, be_n}, 32'h0000_0000);
      @(posedge ref_clk_i) rx_e <= 1'b0;
      for (int i = 0; i < 80 && rd_en !== 1'b0; i++) @(negedge ref_clk_i);
      @(posedge ref_clk_i) rx_e <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      cmp(pops, 2);
      cmp(flushes, 1);
      cmp(pushes, 0);
      cmp(last_ad, 32'h0000_0104);
      i_adma_chip_model.wr(adma_pkg::OFF_WR_ADDR, 32'h0000_0200);
      i_adma_chip_model.wr(adma_pkg::OFF_WR_CNT, 32'h0000_0004);
      cmpb(wr_en, 1'b1);
      @(posedge ref_clk_i) tx_f <= 1'b0;
      repeat (30) @(posedge ref_clk_i);
      tx_f <= 1'b1;
      cmp(pushes, 1);
      cmp(last_ad, 32'h0000_0200);
      rd(adma_pkg::REG_COUNT, 32'h0000_0000);
      cmpb(wr_en, 1'b1);
      @(posedge ref_clk_i) tx_e <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      cmpb(wr_en, 1'b0);
      wr(adma_pkg::REG_CTRL, 32'h0000_0001);
      repeat (3) @(posedge ref_clk_i);
      cmpb(hold_req, 1'b0);
      cmpb(bus_oe, 1'b1);
      i_adma_chip_model.pt(32'h0000_0104);
      rd(adma_pkg::REG_ADDR, 32'h0000_0104);
      i_adma_chip_model.pt(32'h0100_0010);
      rd(adma_pkg::REG_COUNT, 32'h0000_0010);
      cmpb(rd_en, 1'b1);
      cmp(dones, 2);
      rd(8'h10, 32'h0000_0000);
      region <= 2'h1;
      i_adma_chip_model.pt(32'h0000_0008);
      rd(adma_pkg::REG_COUNT, 32'h0000_0010);
      cmp(adrs, 3);
      cmp(rds, 2);
      cmpb(tx_flush_n, 1'b1);
      summarize();
   end
endmodule : adma_top_tb
`default_nettype wire
